// *** hw/spr_port.sv ***
// Device-side serial host port with shared data-out and ready pin
`timescale 1ns/1ps
`default_nettype none
module spr_port
    import spr_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst_b,
    // Serial pins
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // Converter side
    input wire logic conv_done,
    input wire logic [spr_pkg::WORD_BITS-1:0] conv_data,
    output logic [spr_pkg::WORD_BITS-1:0] cfg_word
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic sclk_s1, sclk_s2, sclk_d;
    logic cs_s1, cs_s2;
    logic din_s1, din_s2;

    // Two flops per pin, plus a delayed clock copy for edges
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            {sclk_s1, sclk_s2, sclk_d} <= 3'h7;
            {cs_s1, cs_s2} <= 2'h3;
            {din_s1, din_s2} <= 2'h0;
        end else begin
            {sclk_s1, sclk_s2, sclk_d} <= {sclk, sclk_s1, sclk_s2};
            {cs_s1, cs_s2} <= {cs_b, cs_s1};
            {din_s1, din_s2} <= {din, din_s1};
        end
    end

    wire rise = sclk_s2 & ~sclk_d;
    wire fall = ~sclk_s2 & sclk_d;

    // ****************************************
    // Frame state
    // ****************************************
    spr_state_t state, next_state;
    logic [CNT_W-1:0] cnt;
    logic [WORD_BITS-1:0] in_sr;
    logic [WORD_BITS-1:0] out_sr;
    logic [FIELD_W-1:0] field;
    logic [WORD_BITS-1:0] regs [REG_NUM];
    logic rdy_n;
    logic reissue;
    logic [WORD_BITS-1:0] pend;

    // Decode of the frame events
    wire [WORD_BITS-1:0] word_in = {in_sr[WORD_BITS-2:0], din_s2};
    wire [FIELD_W-1:0] cmd_field = word_in[FIELD_W-1:0];
    wire cmd_rd = word_in[CMD_RD_POS];
    wire cmd_end = rise & (state == ST_CMD) & (cnt == CMD_LAST);
    wire wr_end = rise & (state == ST_WR) & (cnt == WORD_LAST);
    wire rd_end = rise & (state == ST_RD) & (cnt == WORD_LAST);
    wire wr_fire = wr_end & spr_mapped(field) & (field != DATA_IDX);
    wire rd_data = rd_end & (field == DATA_IDX);
    wire [WORD_BITS-1:0] rd_word =
        spr_mapped(cmd_field) ? regs[cmd_field[IDX_W-1:0]] : REG_RST;

    // Next frame state
    // RULE_10: command again without deselect
    always_comb begin
        next_state = state;
        if (cmd_end) begin
            next_state = cmd_rd ? ST_RD : ST_WR;
        end else if (wr_end || rd_end) begin
            next_state = ST_CMD;
        end
    end

    // Frame sequencer; a high chip select aborts any frame
    // RULE_08: deselect aborts frame
    always_ff @(posedge clk) begin
        if (!rst_b || cs_s2) begin
            state <= ST_CMD;
            cnt <= CNT_ZERO;
        end else if (rise) begin
            state <= next_state;
            cnt <= (cmd_end || wr_end || rd_end) ? CNT_ZERO : cnt + CNT_ONE;
        end
    end

    // RULE_05: sample on rising edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            in_sr <= REG_RST;
        end else if (rise && !cs_s2) begin
            in_sr <= word_in;
        end
    end

    // Command byte keeps the target register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            field <= FIELD_RST;
        end else if (cmd_end) begin
            field <= cmd_field;
        end
    end

    // RULE_07: load any register, RULE_01: shift on falling edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_sr <= REG_RST;
        end else if (cmd_end && cmd_rd) begin
            out_sr <= rd_word;
        end else if (fall && state == ST_RD) begin
            out_sr <= {out_sr[WORD_BITS-2:0], 1'b0};
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    // RULE_06: write to selected register
    for (genvar i = 0; i < REG_NUM; i++) begin : g_reg
        if (i == int'(DATA_IDX)) begin : g_data
            // Conversion result, loaded only by the converter
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    regs[i] <= REG_RST;
                end else if (conv_done && rdy_n) begin
                    regs[i] <= conv_data;
                end else if (reissue) begin
                    regs[i] <= pend;
                end
            end
        end else begin : g_ctl
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    regs[i] <= REG_RST;
                end else if (wr_fire && field[IDX_W-1:0] == IDX_W'(i)) begin
                    regs[i] <= word_in;
                end
            end
        end
    end

    // ****************************************
    // Ready flag
    // ****************************************
    // RULE_04: unread result lifts the flag for a cycle before the update
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdy_n <= 1'b1;
            reissue <= 1'b0;
            pend <= REG_RST;
        end else if (conv_done && !rdy_n) begin
            rdy_n <= 1'b1;
            reissue <= 1'b1;
            pend <= conv_data;
        end else if (conv_done || reissue) begin
            // RULE_03: low on conversion complete
            rdy_n <= 1'b0;
            reissue <= 1'b0;
        end else if (rd_data) begin
            rdy_n <= 1'b1;
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    // RULE_02: release pin while deselected, RULE_12: data then flag
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dout <= 1'b1;
            dout_oe <= 1'b0;
            cfg_word <= REG_RST;
        end else begin
            dout_oe <= ~cs_s2;
            cfg_word <= regs[CFG_IDX[IDX_W-1:0]];
            if (state == ST_RD && !cs_s2) begin
                dout <= fall ? out_sr[WORD_BITS-1] : dout;
            end else begin
                dout <= rdy_n;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_shift_fall;
        @(posedge clk) disable iff (!rst_b)
        (fall && state == ST_RD && !cs_s2) |=>
            dout == $past(out_sr[WORD_BITS-1]);
    endproperty
    a_shift_fall: assert property (p_shift_fall) // RULE_01
        else $error("read bit not shifted on falling edge");

    property p_release;
        @(posedge clk) disable iff (!rst_b) cs_s2 |=> !dout_oe;
    endproperty
    a_release: assert property (p_release) // RULE_02
        else $error("pin driven while deselected");

    property p_flag;
        @(posedge clk) disable iff (!rst_b)
        (!cs_s2 && state != ST_RD) |=> (dout == $past(rdy_n)) && dout_oe;
    endproperty
    a_flag: assert property (p_flag) // RULE_03
        else $error("pin does not show ready flag");

    property p_unread;
        @(posedge clk) disable iff (!rst_b)
        (conv_done && !rdy_n) |=> rdy_n ##1 !rdy_n;
    endproperty
    a_unread: assert property (p_unread) // RULE_04
        else $error("flag not lifted before update");

    property p_sample;
        @(posedge clk) disable iff (!rst_b)
        (rise && !cs_s2) |=> in_sr[0] == $past(din_s2);
    endproperty
    a_sample: assert property (p_sample) // RULE_05
        else $error("input bit not sampled on rising edge");

    property p_write;
        @(posedge clk) disable iff (!rst_b)
        wr_fire |=> regs[$past(field[IDX_W-1:0])] == $past(word_in);
    endproperty
    a_write: assert property (p_write) // RULE_06
        else $error("register write lost");

    property p_load;
        @(posedge clk) disable iff (!rst_b)
        (cmd_end && cmd_rd) |=> out_sr == $past(rd_word);
    endproperty
    a_load: assert property (p_load) // RULE_07
        else $error("output shift register not loaded");

    property p_abort;
        @(posedge clk) disable iff (!rst_b)
        cs_s2 |=> state == ST_CMD && cnt == CNT_ZERO;
    endproperty
    a_abort: assert property (p_abort) // RULE_08
        else $error("frame not reset by chip select");

    property p_read_end;
        @(posedge clk) disable iff (!rst_b)
        (rd_data && !conv_done && !reissue) |=> rdy_n ##1 dout;
    endproperty
    a_read_end: assert property (p_read_end) // RULE_12
        else $error("pin not back to flag after read");
endmodule : spr_port
`default_nettype wire

// *** include/spr_pkg.sv ***
// Constants, types and helpers for the serial port with ready flag
// Operation
// RULE_01: The device shifts each output bit out on the serial clock falling edge so it is valid at the next rising edge.
// RULE_02: While chip select is high the data-out/ready pin is not driven.
// RULE_03: With chip select low and no read under way the pin is a ready flag that goes low once a conversion completes.
// RULE_04: If a completed result is not read the ready flag returns high before the next result update.
// RULE_05: The device samples the data input on each serial clock rising edge and the host holds it stable there.
// RULE_06: Data shifted in is written to the register chosen by the target field of the last command byte; the code ignores writes to DATA_IDX.
// RULE_07: The output shift register can be loaded from any on-chip register so each can be read back.
// RULE_08: Chip select is active low and may be tied low permanently by the host.
// RULE_09: The host may use the ready flag falling edge as a result-available interrupt.
// RULE_10: With chip select held low the port runs on serial clock, data in and data-out/ready alone.
// RULE_11: The host starts each transaction with a command byte naming the target register and direction.
// RULE_12: During a read the pin carries read data and goes back to the ready flag when the read ends.
package spr_pkg;
    // ****************************************
    // Frame layout
    // ****************************************
    localparam int CMD_BITS = 8;
    localparam int WORD_BITS = 16;
    localparam int FIELD_W = 6;
    localparam int IDX_W = 3;
    localparam int REG_NUM = 8;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CMD_LAST = 4'h7;
    localparam logic [CNT_W-1:0] WORD_LAST = 4'hf;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam int CMD_RD_POS = 6;
    // ****************************************
    // Register indices and reset values
    // ****************************************
    localparam logic [FIELD_W-1:0] DATA_IDX = 6'h04;
    localparam logic [FIELD_W-1:0] CFG_IDX = 6'h01;
    localparam logic [WORD_BITS-1:0] REG_RST = 16'h0000;
    localparam logic [FIELD_W-1:0] FIELD_RST = 6'h00;

    typedef enum logic [1:0] {
        ST_CMD = 2'b00,
        ST_WR = 2'b01,
        ST_RD = 2'b10
    } spr_state_t;

    // True when the target field names an implemented register
    function automatic logic spr_mapped(input logic [FIELD_W-1:0] field);
        spr_mapped = (field < FIELD_W'(REG_NUM));
    endfunction : spr_mapped
endpackage : spr_pkg

// *** tb/serial_port_with_ready_flag_bench.sv ***
// Self-checking bench for the serial port with ready flag
`timescale 1ns/1ps
`default_nettype none
module serial_port_with_ready_flag_bench;
    import spr_pkg::*;
    logic clk, rst_b, sclk, cs_b, din, dout, dout_oe, conv_done, rd_strobe;
    logic hi;
    logic [15:0] conv_data, cfg_word, rd_word, w;
    logic [15:0] exp_q[$];
    int failures = 0, n_compared = 0, cycles = 0, seed = 39387;
    spr_port dut_u (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
        .din(din), .dout(dout), .dout_oe(dout_oe), .conv_done(conv_done),
        .conv_data(conv_data), .cfg_word(cfg_word));
    spr_host host_u (.clk(clk), .sclk(sclk), .cs_b(cs_b), .din(din),
        .dout(dout), .dout_oe(dout_oe), .rd_strobe(rd_strobe),
        .rd_word(rd_word));
    // Clock of 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ****************************************
    // Compare and report
    // ****************************************
    task automatic ck1(input logic g, input logic e, input string m);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t %s", $time, m);
        end
    endtask : ck1
    task automatic ckw(input logic [15:0] g, input logic [15:0] e,
                       input string m);
        ck1(g === e, 1'b1, m);
    endtask : ckw
    task automatic give_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // Read words against the oldest note
    always @(posedge clk) begin
        if (rd_strobe && exp_q.size() == 0)
            ck1(1'b0, 1'b1, "extra read");
        else if (rd_strobe) ckw(rd_word, exp_q.pop_front(), "rd");
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("BAD t=%0t timeout", $time);
            give_verdict();
        end
    end
    // ****************************************
    // Stimulus
    // ****************************************
    task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic k);
        host_u.xfer({2'b00, a}, d, k);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [15:0] e, input logic k);
        exp_q.push_back(e);
        host_u.xfer({2'b01, a}, 16'h0000, k);
    endtask : rd
    task automatic conv(input logic [15:0] d);
        @(negedge clk);
        conv_done = 1'b1;
        conv_data = d;
        @(negedge clk);
        conv_done = 1'b0;
        conv_data = ~d;
    endtask : conv
    initial begin
        rst_b = 1'b0;
        conv_done = 1'b0;
        conv_data = 16'h0000;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        ck1(dout_oe, 1'b0, "oe reset");
        ckw(cfg_word, REG_RST, "cfg reset");
        for (int i = 0; i < 4; i++) begin
            w = 16'($random(seed));
            wr(CFG_IDX, w, 1'b0);
            ckw(cfg_word, w, "cfg wr");
            rd(CFG_IDX, w, 1'b0);
            repeat (2) @(negedge clk);
            ck1(dout_oe, 1'b0, "oe cs high");
        end
        wr(6'h07, 16'h5a3c, 1'b0);
        rd(6'h07, 16'h5a3c, 1'b0);
        wr(6'h09, 16'hffff, 1'b0);
        rd(6'h09, 16'h0000, 1'b0);
        wr(DATA_IDX, 16'hbeef, 1'b0);
        rd(DATA_IDX, REG_RST, 1'b0);
        host_u.abort_frame();
        rd(CFG_IDX, w, 1'b0);
        host_u.sel(1'b0);
        repeat (2) @(negedge clk);
        ck1(dout_oe, 1'b1, "oe cs low");
        ck1(dout, 1'b1, "flag idle");
        w = 16'($random(seed));
        conv(w);
        host_u.wait_ready(hi);
        ck1(hi, 1'b1, "ready edge");
        ck1(dout, 1'b0, "flag low");
        conv(w + 16'h0001);
        hi = dout;
        repeat (3) begin
            @(negedge clk);
            hi = hi | dout;
        end
        ck1(hi, 1'b1, "flag pulse");
        ck1(dout, 1'b0, "flag low again");
        rd(DATA_IDX, w + 16'h0001, 1'b1);
        ck1(dout, 1'b1, "flag after read");
        wr(CFG_IDX, ~w, 1'b1);
        ckw(cfg_word, ~w, "3-wire wr");
        repeat (10) @(negedge clk);
        ck1(exp_q.size() == 0, 1'b1, "reads missing");
        give_verdict();
    end
endmodule : serial_port_with_ready_flag_bench
`default_nettype wire

// *** tb/spr_host.sv ***
// Host serial master model for the port's serial pins
`timescale 1ns/1ps
`default_nettype none
module spr_host (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic sclk,
    output logic cs_b,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe,
    // Read results
    output logic rd_strobe,
    output logic [15:0] rd_word
);
    logic pin;
    // ****************************************
    // Pin level
    // ****************************************
    // Released pin shows the inverse so stale data never matches
    assign pin = dout_oe ? dout : ~dout;
    initial begin
        sclk = 1'b1;
        cs_b = 1'b1;
        din = 1'b0;
        rd_strobe = 1'b0;
        rd_word = 16'h0000;
    end
    // Half a serial clock period
    task automatic h4;
        repeat (4) @(negedge clk);
    endtask : h4
    task automatic sel(input logic lvl);
        @(negedge clk);
        cs_b = lvl;
        h4();
    endtask : sel
    // command byte then word, MSB first
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                        input logic keep);
        logic [23:0] sh;
        logic [15:0] got;
        sh = {cmd, wd};
        got = 16'h0000;
        sel(1'b0);
        for (int i = 23; i >= 0; i--) begin
            // data moves on fall, stable at rise
            sclk = 1'b0;
            din = sh[i];
            h4();
            // Read bit is taken as the serial clock rises
            if (i < 16) got = {got[14:0], pin};
            sclk = 1'b1;
            h4();
        end
        din = ~din;
        cs_b = keep ? 1'b0 : 1'b1;
        if (cmd[6]) begin
            rd_word = got;
            rd_strobe = 1'b1;
            @(negedge clk);
            rd_strobe = 1'b0;
        end
        h4();
    endtask : xfer
    // falling ready edge taken as result interrupt
    task automatic wait_ready(output logic seen);
        logic last;
        last = pin;
        seen = 1'b0;
        repeat (16) begin
            @(negedge clk);
            if (last && !pin) seen = 1'b1;
            last = pin;
        end
    endtask : wait_ready
    // Four clocks of a frame, then deselect
    task automatic abort_frame;
        sel(1'b0);
        repeat (4) begin
            sclk = 1'b0;
            din = 1'b1;
            h4();
            sclk = 1'b1;
            h4();
        end
        sel(1'b1);
        h4();
    endtask : abort_frame
endmodule : spr_host
`default_nettype wire
